// >>> hdl/mcd_pkg.sv
// Command codes, field positions and decoded-command types for the monitor command decoder
package mcd_pkg;
  localparam int CODE_W = 11;
  localparam int WORD_W = 16;
  // Fixed command codes
  localparam logic [10:0] CC_WR_CFG_A = 11'h001;
  localparam logic [10:0] CC_WR_CFG_B = 11'h024;
  localparam logic [10:0] CC_RD_CFG_A = 11'h002;
  localparam logic [10:0] CC_RD_CFG_B = 11'h026;
  localparam logic [10:0] CC_RD_CELL_A = 11'h004;
  localparam logic [10:0] CC_RD_CELL_B = 11'h006;
  localparam logic [10:0] CC_RD_CELL_C = 11'h008;
  localparam logic [10:0] CC_RD_CELL_D = 11'h00A;
  localparam logic [10:0] CC_RD_CELL_E = 11'h009;
  localparam logic [10:0] CC_RD_CELL_F = 11'h00B;
  localparam logic [10:0] CC_RD_AUX_A = 11'h00C;
  localparam logic [10:0] CC_RD_AUX_B = 11'h00E;
  localparam logic [10:0] CC_RD_AUX_C = 11'h00D;
  localparam logic [10:0] CC_RD_AUX_D = 11'h00F;
  localparam logic [10:0] CC_RD_STAT_A = 11'h010;
  localparam logic [10:0] CC_RD_STAT_B = 11'h012;
  localparam logic [10:0] CC_WR_PULSE = 11'h014;
  localparam logic [10:0] CC_WR_DUTY = 11'h020;
  localparam logic [10:0] CC_WR_DUTY_PB = 11'h01C;
  localparam logic [10:0] CC_RD_PULSE = 11'h016;
  localparam logic [10:0] CC_RD_DUTY = 11'h022;
  localparam logic [10:0] CC_RD_DUTY_PB = 11'h01E;
  localparam logic [10:0] CC_ST_PULSE = 11'h019;
  localparam logic [10:0] CC_CLR_PULSE = 11'h018;
  localparam logic [10:0] CC_CLR_CELL = 11'h711;
  localparam logic [10:0] CC_CLR_AUX = 11'h712;
  localparam logic [10:0] CC_CLR_STAT = 11'h713;
  localparam logic [10:0] CC_POLL = 11'h714;
  localparam logic [10:0] CC_DIAG = 11'h715;
  localparam logic [10:0] CC_WR_XFER = 11'h721;
  localparam logic [10:0] CC_RD_XFER = 11'h722;
  localparam logic [10:0] CC_ST_XFER = 11'h723;
  // Field positions inside the 11-bit code
  localparam int POS_CLASS = 9;
  localparam int POS_RATE = 7;
  localparam int POS_PAT = 5;
  localparam int POS_PULL = 6;
  localparam int POS_DCP = 4;
  localparam int POS_SEL = 0;
  // Class values in bits 10:9
  localparam logic [1:0] CLASS_CELL = 2'h1;
  localparam logic [1:0] CLASS_AUX = 2'h2;
  // Reset values
  localparam logic SDO_IDLE = 1'b1;

  typedef enum logic [5:0] {
    OP_NONE, OP_WR_CFG_A, OP_WR_CFG_B, OP_RD_CFG_A, OP_RD_CFG_B,
    OP_RD_CELL_A, OP_RD_CELL_B, OP_RD_CELL_C, OP_RD_CELL_D, OP_RD_CELL_E, OP_RD_CELL_F,
    OP_RD_AUX_A, OP_RD_AUX_B, OP_RD_AUX_C, OP_RD_AUX_D, OP_RD_STAT_A, OP_RD_STAT_B,
    OP_WR_PULSE, OP_WR_DUTY, OP_WR_DUTY_PB, OP_RD_PULSE, OP_RD_DUTY, OP_RD_DUTY_PB,
    OP_ST_PULSE, OP_CLR_PULSE, OP_CELL_CONV, OP_CELL_OPEN, OP_CELL_TEST, OP_OVERLAP,
    OP_GPIO_CONV, OP_GPIO_OPEN, OP_GPIO_TEST, OP_STAT_CONV, OP_STAT_TEST,
    OP_CELL_GPIO, OP_CELL_SUM, OP_CLR_CELL, OP_CLR_AUX, OP_CLR_STAT,
    OP_POLL, OP_DIAG, OP_WR_XFER, OP_RD_XFER, OP_ST_XFER
  } mcd_op_e;

  typedef struct packed {
    mcd_op_e op;
    logic [1:0] rate;
    logic discharge_permit_bit;
    logic [2:0] sel;
    logic pull_up;
    logic [1:0] pattern;
    logic redundant;
  } mcd_cmd_s;

  typedef enum {ST_IDLE, ST_POLL} mcd_state_e;
endpackage

// >>> hdl/mcd_decoder.sv
// Monitor command decoder: 11-bit command code to operation and option fields
module mcd_decoder
  import mcd_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  // Command word from the framing logic
  input wire logic CMD_VALID,
  input wire logic [WORD_W-1:0] CMD_WORD,
  // Link and converter status
  input wire logic CS_N,
  input wire logic ADC_BUSY,
  // Decoded command
  output logic OP_VALID,
  output mcd_cmd_s OP,
  output logic CMD_IGNORED,
  // Polling
  output logic POLL_ACTIVE,
  output logic SERIAL_DATA_OUT
);

  logic [CODE_W-1:0] cc;
  logic [4:0] top_bits;
  logic [1:0] cls;
  logic [1:0] pat;
  logic is_cell;
  logic is_aux;
  logic m_cell_conv;
  logic m_cell_open;
  logic m_cell_test;
  logic m_overlap;
  logic m_gpio_conv;
  logic m_gpio_open;
  logic m_gpio_test;
  logic m_stat_conv;
  logic m_stat_test;
  logic m_cell_gpio;
  logic m_cell_sum;
  logic word_ok;
  mcd_op_e op_dec;
  logic polls;
  logic known;
  mcd_cmd_s cmd_d;
  mcd_cmd_s cmd_q;
  logic op_valid_q;
  logic ignored_q;
  mcd_state_e state_q;
  mcd_state_e state_d;
  logic sdo_q;
  logic sdo_d;
  logic poll_q;

  // Field split; code bits 10:8 come in the low bits of the first command byte
  assign cc = CMD_WORD[CODE_W-1:0];
  assign top_bits = CMD_WORD[WORD_W-1:CODE_W];
  assign word_ok = (top_bits == 5'h00);
  assign cls = cc[POS_CLASS+1:POS_CLASS];
  assign pat = cc[POS_PAT+1:POS_PAT];
  assign is_cell = (cls == CLASS_CELL);
  assign is_aux = (cls == CLASS_AUX);

  // Pattern matches for the commands with embedded options
  assign m_cell_conv = is_cell && pat == 2'h3 && !cc[3];
  assign m_cell_open = is_cell && cc[5] && cc[3];
  assign m_cell_test = is_cell && cc[4:0] == 5'h07;
  assign m_overlap = is_cell && pat == 2'h0 && cc[3:0] == 4'h1;
  assign m_gpio_conv = is_aux && cc[4:3] == 2'h0 && (pat == 2'h3 || pat == 2'h0);
  assign m_gpio_open = is_aux && !cc[5] && cc[4] && !cc[3];
  assign m_gpio_test = is_aux && cc[4:0] == 5'h07;
  assign m_stat_conv = is_aux && cc[4:3] == 2'h1 && (pat == 2'h3 || pat == 2'h0);
  assign m_stat_test = is_aux && cc[4:0] == 5'h0F;
  assign m_cell_gpio = is_aux && pat == 2'h3 && cc[3:0] == 4'hF;
  assign m_cell_sum = is_aux && pat == 2'h3 && cc[3:0] == 4'h7;

  // Priority: fixed codes, then combined, then self-test, then the rest.
  // Self-test codes overlap group 7 of plain conversions, so they go first.
  always_comb begin
    op_dec = OP_NONE;
    case (cc)
      CC_WR_CFG_A: op_dec = OP_WR_CFG_A;
      CC_WR_CFG_B: op_dec = OP_WR_CFG_B;
      CC_RD_CFG_A: op_dec = OP_RD_CFG_A;
      CC_RD_CFG_B: op_dec = OP_RD_CFG_B;
      CC_RD_CELL_A: op_dec = OP_RD_CELL_A;
      CC_RD_CELL_B: op_dec = OP_RD_CELL_B;
      CC_RD_CELL_C: op_dec = OP_RD_CELL_C;
      CC_RD_CELL_D: op_dec = OP_RD_CELL_D;
      CC_RD_CELL_E: op_dec = OP_RD_CELL_E;
      CC_RD_CELL_F: op_dec = OP_RD_CELL_F;
      CC_RD_AUX_A: op_dec = OP_RD_AUX_A;
      CC_RD_AUX_B: op_dec = OP_RD_AUX_B;
      CC_RD_AUX_C: op_dec = OP_RD_AUX_C;
      CC_RD_AUX_D: op_dec = OP_RD_AUX_D;
      CC_RD_STAT_A: op_dec = OP_RD_STAT_A;
      CC_RD_STAT_B: op_dec = OP_RD_STAT_B;
      CC_WR_PULSE: op_dec = OP_WR_PULSE;
      CC_WR_DUTY: op_dec = OP_WR_DUTY;
      CC_WR_DUTY_PB: op_dec = OP_WR_DUTY_PB;
      CC_RD_PULSE: op_dec = OP_RD_PULSE;
      CC_RD_DUTY: op_dec = OP_RD_DUTY;
      CC_RD_DUTY_PB: op_dec = OP_RD_DUTY_PB;
      CC_ST_PULSE: op_dec = OP_ST_PULSE;
      CC_CLR_PULSE: op_dec = OP_CLR_PULSE;
      CC_CLR_CELL: op_dec = OP_CLR_CELL;
      CC_CLR_AUX: op_dec = OP_CLR_AUX;
      CC_CLR_STAT: op_dec = OP_CLR_STAT;
      CC_POLL: op_dec = OP_POLL;
      CC_DIAG: op_dec = OP_DIAG;
      CC_WR_XFER: op_dec = OP_WR_XFER;
      CC_RD_XFER: op_dec = OP_RD_XFER;
      CC_ST_XFER: op_dec = OP_ST_XFER;
      default: begin
        if (m_cell_gpio) begin
          op_dec = OP_CELL_GPIO;
        end else if (m_cell_sum) begin
          op_dec = OP_CELL_SUM;
        end else if (m_cell_test) begin
          op_dec = OP_CELL_TEST;
        end else if (m_gpio_test) begin
          op_dec = OP_GPIO_TEST;
        end else if (m_stat_test) begin
          op_dec = OP_STAT_TEST;
        end else if (m_cell_conv) begin
          op_dec = OP_CELL_CONV;
        end else if (m_cell_open) begin
          op_dec = OP_CELL_OPEN;
        end else if (m_overlap) begin
          op_dec = OP_OVERLAP;
        end else if (m_gpio_conv) begin
          op_dec = OP_GPIO_CONV;
        end else if (m_gpio_open) begin
          op_dec = OP_GPIO_OPEN;
        end else if (m_stat_conv) begin
          op_dec = OP_STAT_CONV;
        end
      end
    endcase
  end

  assign known = word_ok && (op_dec != OP_NONE);

  // Every conversion start, the pulse start, the poll and the diagnostic poll status
  assign polls = (op_dec == OP_ST_PULSE) || (op_dec == OP_POLL) || (op_dec == OP_DIAG)
    || (cls != 2'h0 && cls != 2'h3);

  // Option fields; fields a command does not carry read as zero
  always_comb begin
    cmd_d = '0;
    cmd_d.op = op_dec;
    if (cls == CLASS_CELL || cls == CLASS_AUX) begin
      cmd_d.rate = cc[POS_RATE+1:POS_RATE];
      cmd_d.sel = cc[POS_SEL+2:POS_SEL];
    end
    case (op_dec)
      OP_CELL_CONV, OP_OVERLAP, OP_CELL_GPIO, OP_CELL_SUM: cmd_d.discharge_permit_bit = cc[POS_DCP];
      OP_CELL_OPEN: begin
        cmd_d.discharge_permit_bit = cc[POS_DCP];
        cmd_d.pull_up = cc[POS_PULL];
      end
      OP_GPIO_OPEN: cmd_d.pull_up = cc[POS_PULL];
      OP_CELL_TEST, OP_GPIO_TEST, OP_STAT_TEST: cmd_d.pattern = pat;
      OP_GPIO_CONV, OP_STAT_CONV: cmd_d.redundant = (pat == 2'h0);
      default: cmd_d.pattern = 2'h0;
    endcase
  end

  // Decoded command register; unknown codes leave it untouched
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cmd_q <= '0;
      op_valid_q <= 1'b0;
      ignored_q <= 1'b0;
    end else if (CE) begin
      op_valid_q <= CMD_VALID && known;
      ignored_q <= CMD_VALID && !known;
      if (CMD_VALID && known) begin
        cmd_q <= cmd_d;
      end
    end
  end

  // Poll state: left when chip select rises or a known command that does not poll arrives
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (CMD_VALID && known && polls && !CS_N) begin
          state_d = ST_POLL;
        end
      end
      ST_POLL: begin
        if (CS_N) begin
          state_d = ST_IDLE;
        end else if (CMD_VALID && known && !polls) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Registered so the pin never glitches on converter status changes
  assign sdo_d = (state_d == ST_POLL) ? !ADC_BUSY : SDO_IDLE;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
      sdo_q <= SDO_IDLE;
      poll_q <= 1'b0;
    end else if (CE) begin
      state_q <= state_d;
      sdo_q <= sdo_d;
      poll_q <= (state_d == ST_POLL);
    end
  end

  assign OP_VALID = op_valid_q;
  assign OP = cmd_q;
  assign CMD_IGNORED = ignored_q;
  // Own flop so the pin does not come from a state compare
  assign POLL_ACTIVE = poll_q;
  assign SERIAL_DATA_OUT = sdo_q;

endmodule // mcd_decoder

// >>> sim/mcd_decoder_properties.sv
// Port-level assertions for the command decoder
module mcd_decoder_properties
  import mcd_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Command and status inputs
  input wire logic CE,
  input wire logic CMD_VALID,
  input wire logic [WORD_W-1:0] CMD_WORD,
  input wire logic CS_N,
  input wire logic ADC_BUSY,
  // Decoder outputs
  input wire logic OP_VALID,
  input wire mcd_cmd_s OP,
  input wire logic CMD_IGNORED,
  input wire logic POLL_ACTIVE,
  input wire logic SERIAL_DATA_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_take(logic [15:0] w);
    CE && CMD_VALID && CMD_WORD == w;
  endsequence
  // Self-test shares bits with the plain pattern and wins, so it is left out
  sequence s_cell_conv;
    CE && CMD_VALID && CMD_WORD[15:9] == 7'h01 && CMD_WORD[6:5] == 2'b11 && !CMD_WORD[3] && CMD_WORD[4:0] != 5'h07;
  endsequence
  chk_write_cfg_a: assert property (s_take(16'h0001) |=> OP_VALID && OP.op == OP_WR_CFG_A)
    else $error("write config A not decoded");
  chk_clear_cell: assert property (s_take(16'h0711) |=> OP_VALID && OP.op == OP_CLR_CELL)
    else $error("clear cell groups not decoded");
  chk_cell_fields: assert property (s_cell_conv |=> OP.op == OP_CELL_CONV && OP.rate == $past(CMD_WORD[8:7])
    && OP.sel == $past(CMD_WORD[2:0]) && OP.discharge_permit_bit == $past(CMD_WORD[4]))
    else $error("cell conversion fields wrong");
  chk_poll_enter: assert property (s_take(16'h0714) ##0 !CS_N |=> POLL_ACTIVE && OP_VALID)
    else $error("poll not entered");
  chk_upper_refused: assert property (CE && CMD_VALID && CMD_WORD[15:11] != 5'h00 |=> CMD_IGNORED && !OP_VALID)
    else $error("word with upper bits set accepted");
  chk_unknown_kept: assert property (s_take(16'h0028) |=> CMD_IGNORED && $stable(OP))
    else $error("unknown code changed state");
  chk_cs_exit: assert property (CE && CS_N |=> !POLL_ACTIVE)
    else $error("poll kept with chip select high");
  chk_busy_low: assert property (CE ##1 POLL_ACTIVE |-> SERIAL_DATA_OUT == !$past(ADC_BUSY))
    else $error("poll output does not follow busy");
  chk_idle_high: assert property (!POLL_ACTIVE |-> SERIAL_DATA_OUT)
    else $error("data output low outside poll");
  chk_one_answer: assert property (!(OP_VALID && CMD_IGNORED))
    else $error("command both decoded and ignored");
endmodule // mcd_decoder_properties

bind mcd_decoder mcd_decoder_properties i_props (.MCLK(MCLK), .RST(RST), .CE(CE), .CMD_VALID(CMD_VALID),
  .CMD_WORD(CMD_WORD), .CS_N(CS_N), .ADC_BUSY(ADC_BUSY), .OP_VALID(OP_VALID), .OP(OP),
  .CMD_IGNORED(CMD_IGNORED), .POLL_ACTIVE(POLL_ACTIVE), .SERIAL_DATA_OUT(SERIAL_DATA_OUT));

// >>> sim/mcd_host.sv
// Host model that frames command words for the decoder
module mcd_host
  import mcd_pkg::*;
(
  // Command link
  output logic CMD_VALID,
  output logic [WORD_W-1:0] CMD_WORD,
  output logic CS_N
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    CMD_VALID = 1'b0;
    CMD_WORD = '0;
    CS_N = 1'b1;
  end
  // Idle word is inverted so a decoder that ignores valid is caught
  task automatic send(input logic vld, input logic [10:0] code, input logic [4:0] hi, input logic cs);
    CMD_VALID = vld;
    CMD_WORD = vld ? {hi, code} : ~CMD_WORD;
    CS_N = cs;
  endtask
endmodule // mcd_host

// >>> sim/tb.sv
// Self-checking bench for the command decoder
module tb
  import mcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [10:0] FIX_CODES [32] = '{11'h001, 11'h024, 11'h002, 11'h026, 11'h004, 11'h006, 11'h008,
    11'h00A, 11'h009, 11'h00B, 11'h00C, 11'h00E, 11'h00D, 11'h00F, 11'h010, 11'h012, 11'h014, 11'h020, 11'h01C,
    11'h016, 11'h022, 11'h01E, 11'h019, 11'h018, 11'h711, 11'h712, 11'h713, 11'h714, 11'h715, 11'h721, 11'h722,
    11'h723};
  logic mclk, rst, ce, adc_busy, cmd_valid, cs_n, op_valid, cmd_ignored, poll_active, serial_data_out, kn, np;
  logic [WORD_W-1:0] cmd_word;
  logic [19:0] e_q;
  logic [31:0] r;
  mcd_cmd_s op, w_exp;
  int n_errors = 0;
  int n_tests = 0;
  mcd_host i_host (.CMD_VALID(cmd_valid), .CMD_WORD(cmd_word), .CS_N(cs_n));
  mcd_decoder i_dut (.MCLK(mclk), .RST(rst), .CE(ce), .CMD_VALID(cmd_valid), .CMD_WORD(cmd_word), .CS_N(cs_n),
    .ADC_BUSY(adc_busy), .OP_VALID(op_valid), .OP(op), .CMD_IGNORED(cmd_ignored), .POLL_ACTIVE(poll_active),
    .SERIAL_DATA_OUT(serial_data_out));
  function automatic mcd_cmd_s exp_cmd(input logic [15:0] w);
    mcd_cmd_s e;
    e = '0;
    if (w[15:11] != 5'h00) return '0;
    for (int i = 0; i < 32; i++) if (w[10:0] == FIX_CODES[i]) e.op = mcd_op_e'(i < 24 ? i + 1 : i + 12);
    if (e.op == OP_NONE && w[10:9] == 2'b01) begin
      if (w[4:0] == 5'b00111) e.op = OP_CELL_TEST;
      else if (w[6:5] == 2'b11 && !w[3]) e.op = OP_CELL_CONV;
      else if (w[5] && w[3]) e.op = OP_CELL_OPEN;
      else if (w[6:5] == 2'b00 && w[3:0] == 4'h1) e.op = OP_OVERLAP;
    end
    if (e.op == OP_NONE && w[10:9] == 2'b10) begin
      if (w[6:5] == 2'b11 && w[3:0] == 4'hF) e.op = OP_CELL_GPIO;
      else if (w[6:5] == 2'b11 && w[3:0] == 4'h7) e.op = OP_CELL_SUM;
      else if (w[4:0] == 5'b00111) e.op = OP_GPIO_TEST;
      else if (w[4:0] == 5'b01111) e.op = OP_STAT_TEST;
      else if (w[4:3] == 2'b00 && w[6] == w[5]) e.op = OP_GPIO_CONV;
      else if (w[5:3] == 3'b010) e.op = OP_GPIO_OPEN;
      else if (w[4:3] == 2'b01 && w[6] == w[5]) e.op = OP_STAT_CONV;
    end
    if (e.op inside {[OP_CELL_CONV:OP_CELL_SUM]}) {e.rate, e.sel} = {w[8:7], w[2:0]};
    e.discharge_permit_bit = (e.op inside {OP_CELL_CONV, OP_CELL_OPEN, OP_OVERLAP, OP_CELL_GPIO, OP_CELL_SUM}) && w[4];
    e.pull_up = (e.op inside {OP_CELL_OPEN, OP_GPIO_OPEN}) && w[6];
    if (e.op inside {OP_CELL_TEST, OP_GPIO_TEST, OP_STAT_TEST}) e.pattern = w[6:5];
    e.redundant = (e.op inside {OP_GPIO_CONV, OP_STAT_CONV}) && w[6:5] == 2'b00;
    return e;
  endfunction
  // Reference of every output, loaded on the taking edge like the outputs
  assign w_exp = exp_cmd(cmd_word);
  assign kn = cmd_valid && w_exp.op != OP_NONE;
  assign np = cs_n ? 1'b0 : (kn ? w_exp.op inside {[OP_CELL_CONV:OP_CELL_SUM], OP_ST_PULSE, OP_POLL, OP_DIAG} : e_q[1]);
  always @(posedge mclk or posedge rst) begin
    if (rst) e_q <= 20'h0_0001;
    else if (ce) e_q <= {kn ? w_exp : e_q[19:4], kn, cmd_valid && !kn, np, np ? !adc_busy : 1'b1};
  end
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input logic vld, input logic [10:0] code, input logic [4:0] hi, input logic cs, busy, en);
    @(negedge mclk);
    check({op, op_valid, cmd_ignored, poll_active, serial_data_out}, e_q);
    i_host.send(vld, code, hi, cs);
    adc_busy = busy;
    ce = en;
  endtask
  task automatic complete_run;
    if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    adc_busy = 1'b0;
    void'($urandom(32'he765_3727));
    repeat (5) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    // Poll with busy falling, then chip select release
    step(1'b1, 11'h714, 5'h00, 1'b0, 1'b1, 1'b1);
    step(1'b0, 11'h000, 5'h00, 1'b0, 1'b1, 1'b1);
    step(1'b0, 11'h000, 5'h00, 1'b0, 1'b0, 1'b1);
    step(1'b0, 11'h000, 5'h00, 1'b1, 1'b0, 1'b1);
    // Every code back to back, mute codes included
    for (int i = 0; i < 2048; i++) step(1'b1, i[10:0], 5'h00, 1'b0, i[2] ^ i[6], 1'b1);
    for (int i = 0; i < 4000; i++) begin
      r = $urandom;
      if (i == 2000) begin
        @(negedge mclk) rst = 1'b1;
        @(negedge mclk) rst = 1'b0;
      end
      step(r[23] | r[24], r[29] ? FIX_CODES[r[4:0]] : r[15:5], r[18:16] == 3'h0 ? {r[22:19], 1'b1} : 5'h00,
        &r[27:25], r[28], r[30] | r[31]);
    end
    step(1'b0, 11'h000, 5'h00, 1'b1, 1'b0, 1'b1);
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    complete_run;
  end
endmodule // tb
